/* File: rtl/dma_chan_pkg.sv */
// constants for the multi-channel dma register block and transfer engine
package dma_chan_pkg;
    // printed register offsets (halfword spaced)
    localparam logic [31:0] CH5_CONTROL_OFS = 32'h5000355C;
    localparam logic [31:0] CH5_PROGRESS_INDEX_OFS = 32'h5000355E;
    localparam logic [31:0] CH6_SOURCE_START_LOW_OFS = 32'h50003560;
    localparam logic [31:0] CH6_SOURCE_START_HIGH_OFS = 32'h50003562;
    localparam logic [31:0] CH6_DEST_START_LOW_OFS = 32'h50003564;
    localparam logic [31:0] CH6_DEST_START_HIGH_OFS = 32'h50003566;
    localparam logic [31:0] CH6_IRQ_THRESHOLD_OFS = 32'h50003568;
    localparam logic [31:0] CH6_TRANSFER_LENGTH_OFS = 32'h5000356A;
    localparam logic [31:0] CH6_CONTROL_OFS = 32'h5000356C;
    localparam logic [31:0] CH_STRIDE = CH6_CONTROL_OFS - CH5_CONTROL_OFS;
    localparam logic [31:0] BLOCK_BASE = CH6_SOURCE_START_LOW_OFS - CH_STRIDE;
    // slot of each register inside a channel, index = (offset - base) / 2
    localparam logic [2:0] SLOT_SRC_LO = 3'((CH6_SOURCE_START_LOW_OFS - CH6_SOURCE_START_LOW_OFS) >> 1);
    localparam logic [2:0] SLOT_SRC_HI = 3'((CH6_SOURCE_START_HIGH_OFS - CH6_SOURCE_START_LOW_OFS) >> 1);
    localparam logic [2:0] SLOT_DST_LO = 3'((CH6_DEST_START_LOW_OFS - CH6_SOURCE_START_LOW_OFS) >> 1);
    localparam logic [2:0] SLOT_DST_HI = 3'((CH6_DEST_START_HIGH_OFS - CH6_SOURCE_START_LOW_OFS) >> 1);
    localparam logic [2:0] SLOT_THRESH = 3'((CH6_IRQ_THRESHOLD_OFS - CH6_SOURCE_START_LOW_OFS) >> 1);
    localparam logic [2:0] SLOT_LENGTH = 3'((CH6_TRANSFER_LENGTH_OFS - CH6_SOURCE_START_LOW_OFS) >> 1);
    localparam logic [2:0] SLOT_CONTROL = 3'((CH6_CONTROL_OFS - CH6_SOURCE_START_LOW_OFS) >> 1);
    localparam logic [2:0] SLOT_INDEX = 3'((CH5_PROGRESS_INDEX_OFS - CH5_CONTROL_OFS) >> 1) + SLOT_CONTROL;
    // control word fields
    localparam int B_ON = 0;
    localparam int B_WIDTH = 1;
    localparam int B_IRQ_EN = 3;
    localparam int B_TRIG = 4;
    localparam int B_DST_INC = 5;
    localparam int B_SRC_INC = 6;
    localparam int B_CIRC = 7;
    localparam int B_PRIO = 8;
    localparam int B_IDLE = 11;
    localparam int B_FILL = 12;
    localparam int B_SENSE = 13;
    localparam logic [15:0] CTRL_WMASK = 16'h3FFF;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [1:0] W_BYTE = 2'h0;
    localparam logic [1:0] W_HALF = 2'h1;
    localparam logic [1:0] W_WORD = 2'h2;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_READ = 4'b0010,
        S_WRITE = 4'b0100,
        S_GAP = 4'b1000
    } eng_state_t;
endpackage

/* File: rtl/dma_channels.sv */
// dma channel registers, arbiter and single shared transfer engine
`timescale 1ns/1ps
module dma_channels
    import dma_chan_pkg::*;
#(
    parameter int NUM_CH = 2,
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CH-1:0] periph_req,
    output logic [NUM_CH-1:0] irq,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [1:0] mem_size,
    output logic bus_lock,
    input wire logic mem_ready,
    input wire logic [31:0] mem_rdata
);
    localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
    localparam int HW = ADDR_W - 5;

    logic [15:0] src_lo [NUM_CH];
    logic [15:0] src_hi [NUM_CH];
    logic [15:0] dst_lo [NUM_CH];
    logic [15:0] dst_hi [NUM_CH];
    logic [15:0] thresh [NUM_CH];
    logic [15:0] length [NUM_CH];
    logic [15:0] ctrl [NUM_CH];
    logic [15:0] progress_index [NUM_CH];
    logic [NUM_CH-1:0] req_meta, req_sync, req_prev, edge_pend;
    logic [CW-1:0] cur;
    logic fill_busy;
    logic [31:0] data;
    eng_state_t state;

    // item size as a shift: 0, 1, 2; the reserved code falls back to bytes
    function automatic logic [1:0] width_shift(input logic [1:0] code);
        return (code == W_HALF) ? 2'h1 : (code == W_WORD) ? 2'h2 : 2'h0;
    endfunction

    function automatic logic [31:0] step_addr(input logic [31:0] start, input logic [15:0] idx,
                                              input logic [1:0] code, input logic inc);
        return inc ? start + ({16'h0000, idx} << width_shift(code)) : start;
    endfunction

    // apb decode
    wire [ADDR_W-3:0] word = paddr[ADDR_W-1:2];
    wire [2:0] slot = word[2:0];
    wire [HW-1:0] ch_field = word[ADDR_W-3:3];
    wire mapped = (ch_field < HW'(NUM_CH)) && (paddr[1:0] == 2'h0);
    wire [CW-1:0] ch_sel = CW'(ch_field);
    wire setup = psel && !penable;
    wire wr_take = psel && penable && pready && pwrite && mapped && (slot != SLOT_INDEX);
    wire bad = !mapped || (pwrite && slot == SLOT_INDEX);
    wire [15:0] rd_val =
        (slot == SLOT_SRC_LO) ? src_lo[ch_sel] : (slot == SLOT_SRC_HI) ? src_hi[ch_sel] :
        (slot == SLOT_DST_LO) ? dst_lo[ch_sel] : (slot == SLOT_DST_HI) ? dst_hi[ch_sel] :
        (slot == SLOT_THRESH) ? thresh[ch_sel] : (slot == SLOT_LENGTH) ? length[ch_sel] :
        (slot == SLOT_CONTROL) ? ctrl[ch_sel] : progress_index[ch_sel];

    // request qualification per channel
    logic [NUM_CH-1:0] go;
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            go[i] = ctrl[i][B_ON] &&
                    (!ctrl[i][B_TRIG] || (ctrl[i][B_SENSE] ? edge_pend[i] : req_sync[i]));
        end
    end

    // scan downward: on equal priority the lower channel overwrites the higher one
    logic [CW-1:0] win;
    logic [2:0] win_prio;
    always_comb begin
        win = '0;
        win_prio = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (go[i] && (win_prio <= ctrl[i][B_PRIO+:3] || !go[win])) begin
                win = CW'(i);
                win_prio = ctrl[i][B_PRIO+:3];
            end
        end
    end

    wire any_go = |go;
    wire [CW-1:0] pick = fill_busy ? cur : win;
    wire pick_go = fill_busy ? go[cur] : any_go;
    wire [15:0] pctl = ctrl[pick];
    wire [15:0] cctl = ctrl[cur];
    wire [15:0] cidx = progress_index[cur];
    wire [31:0] pick_src = step_addr({src_hi[pick], src_lo[pick]}, progress_index[pick],
                                     pctl[B_WIDTH+:2], pctl[B_SRC_INC] && !pctl[B_FILL]);
    wire [31:0] pick_dst = step_addr({dst_hi[pick], dst_lo[pick]}, progress_index[pick],
                                     pctl[B_WIDTH+:2], pctl[B_DST_INC]);
    wire [31:0] cur_dst = step_addr({dst_hi[cur], dst_lo[cur]}, cidx, cctl[B_WIDTH+:2], cctl[B_DST_INC]);
    wire skip_read = pctl[B_FILL] && progress_index[pick] != 16'h0000;
    wire start = state == S_IDLE && pick_go;
    wire wr_done = state == S_WRITE && mem_ready;
    wire last = cidx == length[cur];
    wire keep_on = cctl[B_CIRC] && cctl[B_TRIG];
    wire gap_mode = cctl[B_IDLE] && !cctl[B_TRIG];

    // apb answer: registered, access phase never waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= setup;
            pslverr <= setup && bad;
            prdata <= (setup && mapped) ? {16'h0000, rd_val} : '0;
        end
    end

    // peripheral request synchronisers and rising edge capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_meta <= '0;
            req_sync <= '0;
            req_prev <= '0;
            edge_pend <= '0;
        end else if (ce) begin
            req_meta <= periph_req;
            req_sync <= req_meta;
            req_prev <= req_sync;
            for (int i = 0; i < NUM_CH; i++) begin
                // a new edge in the service cycle survives the clear
                if (req_sync[i] && !req_prev[i]) begin
                    edge_pend[i] <= 1'b1;
                end else if (start && pick == CW'(i)) begin
                    edge_pend[i] <= 1'b0;
                end
            end
        end
    end

    // software registers, hardware index and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                src_lo[i] <= REG_RESET;
                src_hi[i] <= REG_RESET;
                dst_lo[i] <= REG_RESET;
                dst_hi[i] <= REG_RESET;
                thresh[i] <= REG_RESET;
                length[i] <= REG_RESET;
                ctrl[i] <= REG_RESET;
                progress_index[i] <= REG_RESET;
            end
        end else if (ce) begin
            if (wr_done) begin
                if (last) begin
                    progress_index[cur] <= REG_RESET;
                    ctrl[cur][B_ON] <= keep_on;
                end else begin
                    progress_index[cur] <= cidx + 16'h0001;
                end
            end
            // a software write in the same cycle overrides the self-clear
            if (wr_take) begin
                unique case (slot)
                    SLOT_SRC_LO: src_lo[ch_sel] <= pwdata[15:0];
                    SLOT_SRC_HI: src_hi[ch_sel] <= pwdata[15:0];
                    SLOT_DST_LO: dst_lo[ch_sel] <= pwdata[15:0];
                    SLOT_DST_HI: dst_hi[ch_sel] <= pwdata[15:0];
                    SLOT_THRESH: thresh[ch_sel] <= pwdata[15:0];
                    SLOT_LENGTH: length[ch_sel] <= pwdata[15:0];
                    SLOT_CONTROL: ctrl[ch_sel] <= pwdata[15:0] & CTRL_WMASK;
                    default: ;
                endcase
            end
        end
    end

    // transfer engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            cur <= '0;
            fill_busy <= 1'b0;
            data <= '0;
            irq <= '0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= '0;
            mem_size <= W_BYTE;
            bus_lock <= 1'b0;
        end else if (ce) begin
            irq <= '0;
            unique case (state)
                S_IDLE: begin
                    if (pick_go) begin
                        cur <= pick;
                        fill_busy <= pctl[B_FILL];
                        mem_req <= 1'b1;
                        mem_size <= pctl[B_WIDTH+:2];
                        bus_lock <= !pctl[B_IDLE] || pctl[B_FILL];
                        mem_we <= skip_read;
                        mem_addr <= skip_read ? pick_dst : pick_src;
                        state <= skip_read ? S_WRITE : S_READ;
                    end else begin
                        fill_busy <= 1'b0;
                        bus_lock <= 1'b0;
                    end
                end
                S_READ: begin
                    if (mem_ready) begin
                        data <= mem_rdata;
                        mem_wdata <= mem_rdata;
                        mem_we <= 1'b1;
                        mem_addr <= cur_dst;
                        state <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (mem_ready) begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        irq[cur] <= cctl[B_IRQ_EN] && thresh[cur] == cidx;
                        if (last) begin
                            fill_busy <= 1'b0;
                        end
                        if (gap_mode) begin
                            bus_lock <= 1'b0;
                            state <= S_GAP;
                        end else begin
                            state <= S_IDLE;
                        end
                    end else begin
                        mem_wdata <= data;
                    end
                end
                S_GAP: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // second view of arbitration, written apart from the scan above
    logic arb_ok;
    always_comb begin
        arb_ok = 1'b1;
        for (int i = 0; i < NUM_CH; i++) begin
            if (go[i] && (ctrl[i][B_PRIO+:3] > pctl[B_PRIO+:3] ||
                          (ctrl[i][B_PRIO+:3] == pctl[B_PRIO+:3] && CW'(i) < pick))) begin
                arb_ok = 1'b0;
            end
        end
    end

    // checks
    default clocking cb @(posedge pclk iff ce);
    endclocking
    default disable iff (!presetn);

    sequence item_end_s;
        state == S_WRITE && mem_ready;
    endsequence
    sequence gap_walk_s;
        state == S_GAP ##1 state == S_IDLE;
    endsequence

    irq_enable_gate_a: assert property (|irq |-> $past(cctl[B_IRQ_EN]) && $past(thresh[cur] == cidx))
        else $error("interrupt without enable or threshold match");
    irq_thresh_hit_a: assert property (item_end_s and (cctl[B_IRQ_EN] && thresh[cur] == cidx) |=> irq[cur])
        else $error("threshold match missed");
    trig_wait_a: assert property (start && pctl[B_TRIG] |->
        (pctl[B_SENSE] ? edge_pend[pick] : req_sync[pick]))
        else $error("channel started without request");
    fill_one_fetch_a: assert property (state == S_IDLE ##1 state == S_READ |-> !cctl[B_FILL] || cidx == 16'h0000)
        else $error("fill mode fetched source again");
    idle_gap_a: assert property ((item_end_s and gap_mode) |=> gap_walk_s)
        else $error("idle mode gap missing");
    block_back_a: assert property ((item_end_s and !gap_mode) |=> state == S_IDLE && bus_lock == $past(bus_lock))
        else $error("blocking mode inserted gap");
    index_wrap_a: assert property ((item_end_s and last) |=> progress_index[$past(cur)] == 16'h0000)
        else $error("index not cleared at completion");
    on_selfclear_a: assert property ((item_end_s and last and !keep_on and !wr_take) |=> !ctrl[$past(cur)][B_ON])
        else $error("enable not cleared after normal transfer");
    circ_keep_a: assert property ((item_end_s and last and keep_on and !wr_take) |=> ctrl[$past(cur)][B_ON])
        else $error("circular channel lost enable");
    src_step_a: assert property (state == S_IDLE && pick_go && !skip_read |=> mem_addr == $past(pick_src))
        else $error("source address wrong");
    arb_win_a: assert property (start && !fill_busy |-> go[pick] && arb_ok)
        else $error("arbiter picked wrong channel");
    // enable at start, item size, destination address, engine handshake, bus ownership and interrupt pulse width
    chan_off_a: assert property (start |-> pctl[B_ON])
        else $error("disabled channel started");
    item_size_a: assert property (start |=> mem_size == $past(pctl[B_WIDTH+:2]))
        else $error("item size not taken from width code");
    dst_step_a: assert property (state == S_READ && mem_ready |=> mem_we && mem_addr == $past(cur_dst))
        else $error("destination address wrong");
    gap_free_a: assert property (state == S_GAP |-> !bus_lock && !mem_req)
        else $error("bus held during idle gap");
    fill_lock_a: assert property (fill_busy && (state == S_READ || state == S_WRITE) |-> bus_lock)
        else $error("fill transfer left the bus open");
    irq_pulse_a: assert property (|irq |=> irq == '0)
        else $error("interrupt pulse longer than one cycle");
    idle_quiet_a: assert property (state == S_IDLE |-> !mem_req)
        else $error("memory request while engine idle");
    mem_hold_a: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before ready");
endmodule

/* File: tb/mem_model.sv */
// memory side partner: answers reads with an address pattern and logs every access
`timescale 1ns/1ps
module mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ready,
    output logic [31:0] mem_rdata
);
    logic [31:0] wa[$];
    logic [31:0] wd[$];
    logic [31:0] rq[$];
    logic hold;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ready <= 1'b0;
            mem_rdata <= 32'h0;
            hold <= 1'b0;
        end else begin
            if (mem_req && mem_ready) begin
                if (mem_we) begin
                    wa.push_back(mem_addr);
                    wd.push_back(mem_wdata);
                end else begin
                    rq.push_back(mem_addr);
                end
            end
            hold <= slow && !hold;
            mem_ready <= mem_req && !mem_ready && !(slow && !hold);
            // outside a read answer the lines toggle, so stale data never looks valid
            mem_rdata <= (mem_req && !mem_we && !mem_ready) ? (mem_addr ^ 32'h5A5A0000) : ~mem_rdata;
        end
    end
endmodule

/* File: tb/testbench.sv */
// register and transfer tests for the dma channel block
`timescale 1ns/1ps
module testbench;
    import dma_chan_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, se;
    logic mem_req, mem_we, mem_ready, bus_lock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd;
    logic [1:0] periph_req, irq, mem_size;
    int err_total, num_checks, irq_cnt, irq1_cnt, low_run, low_max;
    logic run_on, lk_seen;
    logic [1:0] sz_seen;
    dma_channels #(.NUM_CH(2), .ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_req(periph_req), .irq(irq), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size), .bus_lock(bus_lock),
        .mem_ready(mem_ready), .mem_rdata(mem_rdata));
    mem_model mem (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // interrupt counts, idle spacing between items, size and lock of the last access
    always @(posedge pclk) begin
        if (irq[0] === 1'b1) irq_cnt++;
        if (irq[1] === 1'b1) irq1_cnt++;
        if (mem_req === 1'b1) begin
            if (run_on && low_run > low_max) low_max = low_run;
            run_on = 1'b1;
            low_run = 0;
            sz_seen = mem_size;
            lk_seen = bus_lock;
        end else begin
            low_run++;
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) err_total++;
    endtask
    function automatic logic [11:0] ra(input int c, input logic [2:0] s);
        return 12'(c * 32 + 4 * int'(s));
    endfunction
    task automatic cfg(input int c, input logic [31:0] s, input logic [31:0] d, input logic [15:0] len,
                       input logic [15:0] ctl);
        apb(1, ra(c, SLOT_SRC_LO), {16'h0, s[15:0]});
        apb(1, ra(c, SLOT_SRC_HI), {16'h0, s[31:16]});
        apb(1, ra(c, SLOT_DST_LO), {16'h0, d[15:0]});
        apb(1, ra(c, SLOT_DST_HI), {16'h0, d[31:16]});
        apb(1, ra(c, SLOT_THRESH), 32'h1);
        apb(1, ra(c, SLOT_LENGTH), {16'h0, len});
        apb(1, ra(c, SLOT_CONTROL), {16'h0, ctl});
    endtask
    task automatic done(input int c);
        int n;
        n = 0;
        do begin
            apb(0, ra(c, SLOT_CONTROL), 32'h0);
            n++;
        end while (rd[B_ON] !== 1'b0 && n < 100);
        chk("enable self clear", 32'h0, 32'(rd[B_ON]));
        apb(0, ra(c, SLOT_INDEX), 32'h0);
        chk("index at end", 32'h0, rd);
    endtask
    task automatic clr();
        mem.wa.delete();
        mem.wd.delete();
        mem.rq.delete();
        irq_cnt = 0;
        irq1_cnt = 0;
        run_on = 1'b0;
        low_max = 0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #(50 * 40000);
        err_total++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] s, d, ss;
        presetn = 1'b0;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        periph_req = 2'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ra(1, SLOT_CONTROL), 32'h0);
        chk("control reset", 32'h0, rd);
        apb(1, ra(1, SLOT_SRC_LO), 32'h00001234);
        apb(1, ra(1, SLOT_SRC_HI), 32'h0000ABCD);
        apb(0, ra(1, SLOT_SRC_LO), 32'h0);
        chk("source low", 32'h00001234, rd);
        apb(0, ra(1, SLOT_SRC_HI), 32'h0);
        chk("source high", 32'h0000ABCD, rd);
        apb(1, ra(1, SLOT_DST_HI), 32'hFFFF5AA5);
        apb(0, ra(1, SLOT_DST_HI), 32'h0);
        chk("dest high", 32'h00005AA5, rd);
        apb(1, ra(1, SLOT_CONTROL), 32'hFFFFFFFE);
        apb(0, ra(1, SLOT_CONTROL), 32'h0);
        chk("control mask", 32'h00003FFE, rd);
        apb(1, ra(1, SLOT_CONTROL), 32'h0);
        apb(1, ra(1, SLOT_INDEX), 32'h5);
        chk("index write refused", 32'h1, 32'(se));
        apb(0, 12'h040, 32'h0);
        chk("unmapped error", 32'h1, 32'(se));
        $display("test registers done");
        // copy of three halfwords, interrupt at threshold one
        clr();
        s = 32'h10000100;
        d = 32'h20000200;
        cfg(0, s, d, 16'h2, 16'h0069 | 16'(W_HALF) << B_WIDTH);
        done(0);
        chk("copy writes", 32'h3, 32'(mem.wa.size()));
        for (int k = 0; k < 3; k++) begin
            chk("copy src", s + 32'(2 * k), mem.rq[k]);
            chk("copy dst", d + 32'(2 * k), mem.wa[k]);
            chk("copy data", (s + 32'(2 * k)) ^ 32'h5A5A0000, mem.wd[k]);
        end
        chk("irq count", 32'h1, 32'(irq_cnt));
        chk("copy gap", 32'h1, 32'(low_max));
        chk("copy lock", 32'h1, 32'(lk_seen));
        $display("test copy done");
        // each width, source fixed, slow memory on odd codes, interrupt disabled
        for (int w = 0; w < 3; w++) begin
            clr();
            slow <= w[0];
            cfg(0, s, d, 16'h1, 16'h0021 | 16'(w) << B_WIDTH);
            done(0);
            chk("fixed src", s, mem.rq[1]);
            chk("width step", d + (32'h1 << w), mem.wa[1]);
            chk("no irq", 32'h0, 32'(irq_cnt));
            chk("item size", 32'(w), 32'(sz_seen));
        end
        slow <= 1'b0;
        $display("test widths done");
        // fill: one fetch, same word to four places
        clr();
        cfg(0, s, d, 16'h3, 16'h1061 | 16'(W_WORD) << B_WIDTH);
        done(0);
        chk("fill reads", 32'h1, 32'(mem.rq.size()));
        chk("fill writes", 32'h4, 32'(mem.wa.size()));
        chk("fill data", s ^ 32'h5A5A0000, mem.wd[3]);
        chk("fill dst", d + 32'hC, mem.wa[3]);
        chk("fill lock", 32'h1, 32'(lk_seen));
        $display("test fill done");
        // idle mode: one spare cycle after each store, bus left open
        clr();
        cfg(0, s, d, 16'h1, 16'h0861);
        done(0);
        chk("gap cycles", 32'h2, 32'(low_max));
        chk("gap lock", 32'h0, 32'(lk_seen));
        chk("gap writes", 32'h2, 32'(mem.wa.size()));
        $display("test gap done");
        // edge sensing: a request held high moves one item only
        clr();
        cfg(0, s, d, 16'h1, 16'h2031);
        periph_req <= 2'h1;
        repeat (30) @(posedge pclk);
        chk("edge one item", 32'h1, 32'(mem.wa.size()));
        periph_req <= 2'h0;
        repeat (4) @(posedge pclk);
        periph_req <= 2'h1;
        done(0);
        periph_req <= 2'h0;
        chk("edge two items", 32'h2, 32'(mem.wa.size()));
        $display("test edge done");
        // circular: enable stays set and the index wraps while requests continue
        clr();
        cfg(1, s, 32'h30000000, 16'h1, 16'h00B9);
        periph_req <= 2'h2;
        repeat (40) @(posedge pclk);
        apb(0, ra(1, SLOT_CONTROL), 32'h0);
        chk("circular keeps enable", 32'h1, 32'(rd[B_ON]));
        apb(1, ra(1, SLOT_CONTROL), 32'h00000039);
        done(1);
        periph_req <= 2'h0;
        chk("circular restart", 32'h30000000, mem.wa[2]);
        chk("circular irq", 32'h1, 32'(irq1_cnt > 1));
        $display("test circular done");
        // triggered channels: nothing before a request, then priority decides
        for (int p = 0; p < 2; p++) begin
            clr();
            cfg(0, s, d, 16'h0, 16'h0031 | 16'(p ? 3 : 1) << B_PRIO);
            cfg(1, s, 32'h30000000, 16'h0, 16'h0031 | 16'(p ? 3 : 5) << B_PRIO);
            repeat (20) @(posedge pclk);
            chk("wait for request", 32'h0, 32'(mem.rq.size()));
            periph_req <= 2'h3;
            done(0);
            done(1);
            periph_req <= 2'h0;
            ss = p ? d : 32'h30000000;
            chk("first grant", ss, mem.wa[0]);
        end
        $display("test trigger done");
        tally_and_finish();
    end
endmodule
